// [core/fsp_pkg.sv]
// constants, types and register map of the flash self-program sequencer
package fsp_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WRITE_TIME_NS = 1000000;
  localparam int unsigned ERASE_TIME_NS = 2000000;

  // ---------------------------------------------------------------
  // widths and geometry
  // ---------------------------------------------------------------
  localparam int PTR_W     = 22;
  localparam int ADDR_W    = 21;
  localparam int HOLD_N    = 64;
  localparam int IDX_W     = 6;
  localparam int BLOCK_LSB = 6;
  localparam int ERASE_LSB = 10;
  localparam logic [IDX_W-1:0] IDX_LAST = 6'h3f;
  localparam logic [ERASE_LSB-1:0] ERASE_LOW_ZERO = 10'h000;

  // ---------------------------------------------------------------
  // unlock key
  // ---------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_KEY    = 8'h04;
  localparam logic [7:0] OFS_PTR    = 8'h08;
  localparam logic [7:0] OFS_LATCH  = 8'h0c;
  localparam logic [7:0] OFS_STORE  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_START_BIT  = 1;
  localparam int CTRL_ENABLE_BIT = 2;
  localparam int CTRL_ABORT_BIT  = 3;
  localparam int CTRL_ERASE_BIT  = 4;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_OPEN_BIT   = 1;
  localparam int STAT_HALF_BIT   = 2;

  // table store pointer modes
  localparam logic [1:0] STORE_KEEP     = 2'h0;
  localparam logic [1:0] STORE_POST_INC = 2'h1;
  localparam logic [1:0] STORE_POST_DEC = 2'h2;
  localparam logic [1:0] STORE_PRE_INC  = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FSP_IDLE   = 3'b001,
    FSP_STREAM = 3'b010,
    FSP_TIMED  = 3'b100
  } fsp_phase_type;

  typedef enum logic [2:0] {
    FSP_KEY_NONE = 3'b001,
    FSP_KEY_HALF = 3'b010,
    FSP_KEY_OPEN = 3'b100
  } fsp_key_type;

  typedef struct packed {
    logic              we;
    logic              erase;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fsp_flash_type;

  typedef struct packed {
    fsp_phase_type                phase;
    fsp_key_type                  key;
    logic                         enable;
    logic                         erase_sel;
    logic                         start;
    logic                         is_erase;
    logic                         fresh;
    logic [PTR_W-1:0]             ptr;
    logic [7:0]                   latch;
    logic [HOLD_N-1:0][7:0]       hold;
    logic [IDX_W-1:0]             idx;
    logic [ADDR_W-BLOCK_LSB-1:0]  block;
    logic [31:0]                  timer;
    fsp_flash_type                flash;
    logic [31:0]                  rdata;
  } fsp_state_type;

  typedef struct packed {
    logic marker;
    logic abort;
  } fsp_keep_type;

endpackage : fsp_pkg

// [core/fsp_sequencer.sv]
// flash self-program sequencer: holding registers, unlock, timed write and erase
//
// Contract
// (RULE1) program only whole 64-byte blocks, never single words or bytes
// (RULE2) sixty-four byte-wide holding registers loaded by table stores
// (RULE3) table store is a short write to one holding register only
// (RULE4) core stalls while a long write or erase runs
// (RULE5) internal timer ends the long cycle without software
// (RULE6) holding registers keep their contents after an operation
// (RULE7) software programs each byte at most once between erases
// (RULE8) software erases first, then loads all 64 holding registers
// (RULE9) software sets the enable bit before starting a cycle
// (RULE10) disable irqs, key 55h then aah, then set start
// (RULE11) start accepted only right after the unlock key sequence
// (RULE12) software keeps pointer inside the intended 64-byte range
// (RULE13) enable plus erase select plus unlocked start erases 1024 bytes
// (RULE14) reset during a write leaves the abort flag set
// (RULE15) software verifies written data by table reads
// (RULE16) pointer 5:0 picks holding register, 20:6 picks program block
// (RULE17) erase uses pointer 20:10, ignores 9:0
// (RULE18) start bit only settable by software, cleared by hardware
// (RULE19) hardware clears erase select when erase completes
// (RULE20) start without enable or proper key is ignored; here nothing starts but the abort flag is set
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps

module fsp_sequencer
  import fsp_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS,
  parameter int unsigned ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          por_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  output logic               core_stall,
  output fsp_flash_type      flash
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fsp_state_type q;
  fsp_state_type next_q;
  fsp_keep_type  k;
  fsp_keep_type  next_k;

  logic        wr_take;
  logic        mapped;
  logic [31:0] read_word;
  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;

  localparam logic [31:0] WRITE_LOAD = 32'(WRITE_CYCLES - 1);
  localparam logic [31:0] ERASE_LOAD = 32'(ERASE_CYCLES - 1);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_KEY, OFS_PTR, OFS_LATCH, OFS_STORE, OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // bus held off while the long cycle runs
  assign pready     = (q.phase == FSP_IDLE);  // see (RULE4)
  assign core_stall = (q.phase != FSP_IDLE);  // see (RULE4)
  assign pslverr    = psel & penable & ~mapped;
  assign prdata     = q.rdata;
  assign flash      = q.flash;
  assign wr_take    = psel & penable & pwrite & pready & mapped;

  // table store pointer arithmetic touches the low 21 bits only
  assign ptr_inc = {q.ptr[PTR_W-1], q.ptr[ADDR_W-1:0] + 21'h000001};
  assign ptr_dec = {q.ptr[PTR_W-1], q.ptr[ADDR_W-1:0] - 21'h000001};

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    read_word = 32'h00000000;
    case (paddr)
      OFS_CTRL: begin
        read_word[CTRL_START_BIT]  = q.start;
        read_word[CTRL_ENABLE_BIT] = q.enable;
        read_word[CTRL_ABORT_BIT]  = k.abort;
        read_word[CTRL_ERASE_BIT]  = q.erase_sel;
      end
      OFS_PTR:   read_word[PTR_W-1:0] = q.ptr;
      OFS_LATCH: read_word[7:0] = q.latch;
      OFS_STATUS: begin
        read_word[STAT_BUSY_BIT] = (q.phase != FSP_IDLE);
        read_word[STAT_OPEN_BIT] = (q.key == FSP_KEY_OPEN);
        read_word[STAT_HALF_BIT] = (q.key == FSP_KEY_HALF);
      end
      default: read_word = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_k = k;
    next_q.fresh       = 1'b0;
    next_q.flash.we    = 1'b0;
    next_q.flash.erase = 1'b0;

    if (psel) begin
      next_q.rdata = read_word;
    end

    // a write interrupted by reset is caught on the first cycle after it
    if (q.fresh && k.marker) begin
      next_k.abort  = 1'b1;  // see (RULE14)
      next_k.marker = 1'b0;
    end

    if (wr_take) begin
      // anything but the second key byte breaks the unlock sequence
      next_q.key = FSP_KEY_NONE;  // see (RULE11)
      case (paddr)
        OFS_CTRL: begin
          next_q.enable    = pwdata[CTRL_ENABLE_BIT];
          next_q.erase_sel = pwdata[CTRL_ERASE_BIT];
          next_k.abort     = pwdata[CTRL_ABORT_BIT] | (q.fresh & k.marker);
          // writing zero to start has no effect
          if (pwdata[CTRL_START_BIT]) begin  // see (RULE18)
            if (q.key == FSP_KEY_OPEN && q.enable) begin  // see (RULE10) see (RULE11)
              next_q.start  = 1'b1;
              next_k.marker = 1'b1;
              if (pwdata[CTRL_ERASE_BIT]) begin
                next_q.is_erase    = 1'b1;
                next_q.phase       = FSP_TIMED;
                next_q.flash.erase = 1'b1;  // see (RULE13)
                next_q.flash.addr  = {q.ptr[ADDR_W-1:ERASE_LSB], ERASE_LOW_ZERO};  // see (RULE17)
                next_q.flash.data  = 8'hff;
                next_q.timer       = ERASE_LOAD;
              end else begin
                next_q.is_erase = 1'b0;
                next_q.phase    = FSP_STREAM;  // see (RULE1)
                next_q.block    = q.ptr[ADDR_W-1:BLOCK_LSB];  // see (RULE16)
                next_q.idx      = '0;
              end
            end else begin
              // improper attempt: nothing starts, flag reports it
              next_k.abort = 1'b1;  // see (RULE20) see (RULE9)
            end
          end
        end
        OFS_KEY: begin
          if (pwdata[7:0] == KEY_FIRST) begin
            next_q.key = FSP_KEY_HALF;  // see (RULE10)
          end else if (pwdata[7:0] == KEY_SECOND && q.key == FSP_KEY_HALF) begin
            next_q.key = FSP_KEY_OPEN;  // see (RULE10)
          end
        end
        OFS_PTR: begin
          next_q.ptr = pwdata[PTR_W-1:0];
        end
        OFS_LATCH: begin
          next_q.latch = pwdata[7:0];
        end
        OFS_STORE: begin
          // short write: one holding register, flash untouched
          case (pwdata[1:0])
            STORE_POST_INC: begin
              next_q.hold[q.ptr[IDX_W-1:0]] = q.latch;  // see (RULE3) see (RULE16)
              next_q.ptr = ptr_inc;
            end
            STORE_POST_DEC: begin
              next_q.hold[q.ptr[IDX_W-1:0]] = q.latch;  // see (RULE3)
              next_q.ptr = ptr_dec;
            end
            STORE_PRE_INC: begin
              next_q.hold[ptr_inc[IDX_W-1:0]] = q.latch;  // see (RULE2) see (RULE3)
              next_q.ptr = ptr_inc;
            end
            default: begin
              next_q.hold[q.ptr[IDX_W-1:0]] = q.latch;  // see (RULE2)
            end
          endcase
        end
        default: begin
          next_q.key = FSP_KEY_NONE;
        end
      endcase
    end

    // ---------------------------------------------------------------
    // long cycle sequencer
    // ---------------------------------------------------------------
    case (q.phase)
      FSP_IDLE: begin
      end
      FSP_STREAM: begin
        // whole block presented byte by byte; holding registers left intact
        next_q.flash.we   = 1'b1;  // see (RULE1) see (RULE6)
        next_q.flash.addr = {q.block, q.idx};
        next_q.flash.data = q.hold[q.idx];
        next_q.idx        = q.idx + 6'h01;
        if (q.idx == IDX_LAST) begin
          next_q.phase = FSP_TIMED;
          next_q.timer = WRITE_LOAD;  // see (RULE5)
        end
      end
      FSP_TIMED: begin
        if (q.timer == 32'h00000000) begin
          next_q.phase  = FSP_IDLE;  // see (RULE5)
          next_q.start  = 1'b0;  // see (RULE18)
          next_k.marker = 1'b0;
          if (q.is_erase) begin
            next_q.erase_sel = 1'b0;  // see (RULE19)
          end
        end else begin
          next_q.timer = q.timer - 32'h00000001;
        end
      end
      default: begin
        next_q.phase = FSP_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{phase: FSP_IDLE, key: FSP_KEY_NONE, fresh: 1'b1, default: '0};
    end else begin
      q <= next_q;
    end
  end

  // survives ordinary resets so an interrupted write can be reported
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      k <= '0;
    end else begin
      k <= next_k;  // see (RULE14)
    end
  end

endmodule : fsp_sequencer

// [tb/fsp_sequencer_sva.sv]
// assertion checker for the flash self-program sequencer ports
`timescale 1ns/10ps
module fsp_sequencer_sva
  import fsp_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = 20,
  parameter int unsigned ERASE_CYCLES = 30
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        por_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        core_stall,
  input fsp_flash_type    flash
);
  // ---------------------------------------------------------------
  // run-length counters and unlock key tracker
  // ---------------------------------------------------------------
  logic [6:0]  we_run;
  logic [31:0] stall_cnt;
  logic [1:0]  key_seen;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_run    <= 7'h00;
      stall_cnt <= 32'h0;
      key_seen  <= 2'h0;
    end else begin
      we_run    <= flash.we ? we_run + 7'h01 : 7'h00;
      stall_cnt <= core_stall ? stall_cnt + 32'h1 : 32'h0;
      // last accepted writes: bit0 first key byte, bit1 both key bytes in order
      if (psel && penable && pwrite && pready) begin
        key_seen <= {key_seen[0] && paddr == OFS_KEY && pwdata[7:0] == KEY_SECOND,
                     paddr == OFS_KEY && pwdata[7:0] == KEY_FIRST};
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_stall_ready: assert property (pready == !core_stall)
    else $error("ready and stall disagree");
  a_we_stall: assert property (flash.we |-> core_stall)
    else $error("flash write outside stall");
  a_erase_stall: assert property (flash.erase |-> core_stall)
    else $error("erase outside stall");
  a_erase_low: assert property (flash.erase |-> flash.addr[ERASE_LSB-1:0] == ERASE_LOW_ZERO)
    else $error("erase address low bits not zero");
  a_op_excl: assert property (!(flash.we && flash.erase))
    else $error("write and erase together");
  a_burst_len: assert property (flash.we |-> we_run < 7'h40)
    else $error("write burst too long");
  a_burst_end: assert property ($fell(flash.we) |-> $past(we_run) == 7'h3f)
    else $error("write burst not a whole block");
  a_burst_first: assert property ($rose(flash.we) |-> flash.addr[5:0] == 6'h00)
    else $error("burst does not start at block base");
  a_addr_step: assert property (flash.we && $past(flash.we) |-> flash.addr == $past(flash.addr) + 21'h1)
    else $error("burst address not sequential");
  a_start_taken: assert property ($rose(core_stall) |->
    $past(psel && penable && pwrite && paddr == OFS_CTRL && pwdata[CTRL_START_BIT]))
    else $error("stall without start write");
  a_stall_first: assert property ($rose(core_stall) |-> (flash.erase) or (##1 flash.we))
    else $error("stall without flash operation");
  a_key_before: assert property ($rose(core_stall) |-> $past(key_seen[1]))
    else $error("stall without unlock key");
  a_stall_bound: assert property (core_stall |-> stall_cnt < WRITE_CYCLES + ERASE_CYCLES + 32'd66)
    else $error("long cycle does not end");
endmodule : fsp_sequencer_sva

bind fsp_sequencer fsp_sequencer_sva #(.WRITE_CYCLES(WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_sva (
  .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .core_stall(core_stall), .flash(flash));

// [tb/fsp_flash_model.sv]
// behavioural program flash array on the far side of the sequencer
`timescale 1ns/10ps
module fsp_flash_model
  import fsp_pkg::*;
(
  input wire logic     pclk,
  input fsp_flash_type flash
);
  logic [7:0]        mem [int];
  int                n_we = 0;
  logic [ADDR_W-1:0] last_erase = '0;

  function automatic logic [7:0] get(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : get

  // programming only clears bits, erase restores ones
  always @(posedge pclk) begin
    if (flash.we) begin
      mem[flash.addr] = get(flash.addr) & flash.data;
      n_we++;
    end
    if (flash.erase) begin
      last_erase = flash.addr;
      for (int i = 0; i < 1024; i++)
        mem.delete({flash.addr[ADDR_W-1:ERASE_LSB], i[9:0]});
    end
  end
endmodule : fsp_flash_model

// [tb/test_flash_self_program_sequencer.sv]
// self-checking testbench of the flash self-program sequencer
`timescale 1ns/10ps
module test_flash_self_program_sequencer
  import fsp_pkg::*;
;
  localparam int          WC = 20;
  localparam int          EC = 30;
  localparam logic [31:0] ST = 32'h1 << CTRL_START_BIT;
  localparam logic [31:0] EN = 32'h1 << CTRL_ENABLE_BIT;
  localparam logic [31:0] AB = 32'h1 << CTRL_ABORT_BIT;
  localparam logic [31:0] ER = 32'h1 << CTRL_ERASE_BIT;

  logic          pclk    = 1'b0;
  logic          presetn = 1'b0;
  logic          por_n   = 1'b0;
  logic          psel    = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite  = 1'b0;
  logic [7:0]    paddr   = 8'h00;
  logic [31:0]   pwdata  = 32'h0;
  logic          pready;
  logic [31:0]   prdata;
  logic          pslverr;
  logic          core_stall;
  fsp_flash_type flash;
  int            failures = 0;
  int            n_checks = 0;
  int            seed     = 32'h784e;
  logic [7:0]    hold_ref [HOLD_N];
  logic [31:0]   r;
  logic          e;
  logic [20:0]   base;
  int            n;
  int            we0;
  logic [31:0]   p;
  logic [7:0]    v;
  logic [1:0]    pm;

  always #4 pclk = ~pclk;

  fsp_sequencer #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC)) dut (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .core_stall(core_stall), .flash(flash));
  fsp_flash_model fm (.pclk(pclk), .flash(flash));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic finish_test();
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic start(input logic [20:0] p, input logic [31:0] f);
    apb(1'b1, OFS_PTR, 32'(p));
    apb(1'b1, OFS_CTRL, EN | f);
    apb(1'b1, OFS_KEY, 32'(KEY_FIRST));
    apb(1'b1, OFS_KEY, 32'(KEY_SECOND));
    apb(1'b1, OFS_CTRL, EN | ST | f);
  endtask : start

  task automatic wait_idle(input int x);
    n = 0;
    @(posedge pclk);
    while (core_stall === 1'b1) begin
      n++;
      @(posedge pclk);
    end
    chk(32'(n >= x && n <= x + 1), 32'h1);
  endtask : wait_idle

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk({r[30:0], e}, 32'h1);
    base = 21'($random(seed)) & 21'h1ffc00;
    start(base | 21'h155, ER); // erase first, low bits ignored
    wait_idle(EC);
    chk(32'(fm.last_erase), 32'(base));
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(r, EN);
    we0 = fm.n_we;
    apb(1'b1, OFS_PTR, 32'(base + 21'h40));
    for (int i = 0; i < HOLD_N; i++) begin
      hold_ref[i] = 8'($random(seed));
      apb(1'b1, OFS_LATCH, 32'(hold_ref[i]));
      apb(1'b1, OFS_STORE, 32'(STORE_POST_INC));
    end
    chk(fm.n_we, we0);
    // later blocks reuse the holding registers; the last one first tries every pointer mode
    for (int b = 1; b < 4; b++) begin
      if (b == 3) begin
        p = 32'(base) + 32'h105;
        apb(1'b1, OFS_PTR, p);
        for (int m = 0; m < 8; m++) begin
          v  = 8'($random(seed));
          pm = 2'(m);
          if (pm == STORE_PRE_INC) p = p + 32'h1;
          hold_ref[p[5:0]] = v;
          if (pm == STORE_POST_INC) p = p + 32'h1;
          if (pm == STORE_POST_DEC) p = p - 32'h1;
          apb(1'b1, OFS_LATCH, 32'(v));
          apb(1'b1, OFS_STORE, 32'(pm));
          apb(1'b0, OFS_PTR, 32'h0);
          chk(r, p);
        end
      end
      start(base + 21'(64 * b), 32'h0);
      wait_idle(HOLD_N + WC);
      for (int i = 0; i < HOLD_N; i++)
        chk(32'(fm.get(base + 21'(64 * b + i))), 32'(hold_ref[i]));
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(r, EN);
    end
    // no key, reversed key, enable clear before start
    for (int k = 0; k < 3; k++) begin
      we0 = fm.n_we;
      apb(1'b1, OFS_CTRL, k == 2 ? 32'h0 : EN);
      if (k > 0) begin
        apb(1'b1, OFS_KEY, 32'(k == 1 ? KEY_SECOND : KEY_FIRST));
        apb(1'b1, OFS_KEY, 32'(k == 1 ? KEY_FIRST : KEY_SECOND));
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(r, k == 1 ? 32'h1 << STAT_HALF_BIT : 32'h1 << STAT_OPEN_BIT);
      end
      apb(1'b1, OFS_CTRL, EN | ST);
      @(posedge pclk);
      chk(32'(core_stall), 32'h0);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(r, EN | AB);
      chk(fm.n_we, we0);
    end
    apb(1'b1, OFS_CTRL, EN);
    start(base + 21'h100, 32'h0);
    repeat (10) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(r & AB, AB);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    finish_test();
  end
endmodule : test_flash_self_program_sequencer
